// ### rtl/servo_pins_pkg.sv
/*
  Constants, encodings and timing counts for the servo controller pin-level block.
  Assumes a single 40 MHz system clock; the host and the encoder are asynchronous to it.
*/
// How it works
// - capture the index position only while index, phase A and phase B are all low.
// - forward motion means phase A leads phase B by a quarter cycle.
// - every edge of both phases counts, four counts per encoder line.
// - 8-bit host bus carries commands, status, data under select, read, write, port select.
// - port select low means command write or status read; high means data port.
// - host interrupt goes high while any enabled interrupt flag is set, once init after reset is done.
// - 8-bit mode latches the value with MSB on port bit 0, LSB on bit 7.
// - 12-bit mode sends two 6-bit words on lines 0-5, low word first, MSB on line 0.
// - 12-bit mode line 6 is low for the low word, high for the high word.
// - 12-bit mode line 7 rises to strobe each word into the converter.
// - PWM mode puts sign on line 0, magnitude on line 1, other lines unused.
// - chip reset is active low, acts on release, held low at least 8 clocks.
// - reset clears filter coefficient and trajectory values and zeroes position.
// - reset loads error threshold 7FFF and makes it active as after a threshold load.
// - after reset breakpoint interrupt is masked, the five others are enabled.
// - reset sets the derivative interval to its minimum of 2048 clocks.
// - during reset the port shows 12-bit mid-scale 800, then 8-bit mid-scale 80.
// - status reads 00 after release, then 84 within 1.5 ms.
// - busy is valid by the first moment the host can read it after a transfer.
// - position error is desired minus actual position, sent on to the filter.
// - each encoder input is synchronised to the clock before decoding.
// - each quadrature transition steps the position up or down by direction.
// - an armed index capture stores the position and raises an interrupt flag.
package servo_pins_pkg;

  localparam real CLK_MHZ         = 40.0;
  localparam real INIT_TIME_MS    = 1.5;
  localparam int  INIT_CYCLES     = int'(INIT_TIME_MS * 1000.0 * CLK_MHZ - 0.5);
  localparam int  RST_MIN_CLOCKS  = 8;
  localparam int  DS_BASE_CLOCKS  = 2048;

  localparam logic [15:0] ETHR_RST      = 16'h7FFF;
  localparam logic [11:0] MIDSCALE12    = 12'h800;
  localparam logic [7:0]  MIDSCALE8     = 8'h80;
  localparam logic [7:0]  STATUS_INIT   = 8'h84;
  localparam logic [31:0] POS_MAX       = 32'h3FFFFFFF;
  localparam logic [31:0] POS_MIN       = 32'hC0000000;
  localparam logic [15:0] SYNC_IDLE     = 16'h9E00;

  // flag index n sits at status bit n+1; busy is bit 0, motor off bit 7
  localparam int FL_CMD_ERR = 0;
  localparam int FL_TRAJ    = 1;
  localparam int FL_INDEX   = 2;
  localparam int FL_WRAP    = 3;
  localparam int FL_POS_ERR = 4;
  localparam int FL_BREAK   = 5;
  localparam logic [5:0] MASK_RST = 6'h1F;

  typedef enum logic [1:0] {MODE_8 = 2'h0, MODE_12 = 2'h1, MODE_PWM = 2'h3} motor_mode_t;
  typedef enum logic [1:0] {MX_LO = 2'h0, MX_LO_STB = 2'h1, MX_HI = 2'h3, MX_HI_STB = 2'h2} mux_state_t;

  localparam logic [7:0] CMD_IRQ_CLR  = 8'h01;
  localparam logic [7:0] CMD_MASK  = 8'h02;
  localparam logic [7:0] CMD_THR_LOAD = 8'h03;
  localparam logic [7:0] CMD_LDES  = 8'h04;
  localparam logic [7:0] CMD_LCOEF = 8'h05;
  localparam logic [7:0] CMD_LDS   = 8'h06;
  localparam logic [7:0] CMD_ARM   = 8'h07;
  localparam logic [7:0] CMD_RDPOS = 8'h08;
  localparam logic [7:0] CMD_RDIDX = 8'h09;
  localparam logic [7:0] CMD_MTON  = 8'h0A;
  localparam logic [7:0] CMD_MTOFF = 8'h0B;

endpackage

// ### rtl/servo_pins.sv
/*
  Pin-level logic of the servo controller: encoder decode and index capture, host port
  with command, status and data bytes, interrupt, motor output formats, reset sequence.
  Assumes the filter and trajectory logic sit outside and exchange values on plain ports.
*/
`timescale 1ns/10ps
`default_nettype none
module servo_pins
  import servo_pins_pkg::*;
#(
  parameter int INIT_CYCLES_P = INIT_CYCLES,
  parameter int DS_BASE_P     = DS_BASE_CLOCKS
) (
  input  wire logic        clk_i,                 // 40 MHz system clock
  input  wire logic        sys_rst_i,             // async reset, active high
  input  wire logic        chip_rst_n_i,          // reset pin, active low
  input  wire logic        enc_a_i,               // encoder phase A
  input  wire logic        enc_b_i,               // encoder phase B
  input  wire logic        enc_index_n_i,         // index, active low
  input  wire logic        host_cs_n_i,           // device select
  input  wire logic        host_rd_n_i,           // read strobe
  input  wire logic        host_wr_n_i,           // write strobe
  input  wire logic        port_select_i,         // 0 command, 1 data
  input  wire logic [7:0]  host_data_bus_i,       // bus level in
  output logic      [7:0]  host_data_bus_o,       // bus drive value
  output logic             host_data_bus_oe_n_o,  // low while driving
  output logic             host_irq_o,            // interrupt, active high
  input  wire logic [1:0]  motor_mode_i,          // output format strap
  input  wire logic [11:0] filter_out_i,          // filter drive, offset binary
  input  wire logic        filter_valid_i,        // new drive value
  input  wire logic        breakpoint_hit_i,      // breakpoint event pulse
  output logic      [7:0]  motor_out_port_o,      // motor output port
  output logic      [31:0] pos_error_o,           // error to filter
  output logic      [31:0] desired_pos_o,         // desired position
  output logic      [15:0] error_threshold_o,     // error threshold
  output logic      [15:0] filter_coef_o,         // filter coefficient
  output logic             deriv_tick_o,          // derivative sample pulse
  output logic             motor_off_o            // motor held at mid-scale
);

  localparam int IW = $clog2(INIT_CYCLES_P + 1);

  initial begin
    if (INIT_CYCLES_P < 1 || DS_BASE_P < 1 || DS_BASE_P * 256 > 1048576)
      $error("servo_pins: unsupported timing parameter");
  end

  // ---------------- pin synchronisers
  logic [15:0] sync1_q, sync2_q;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end
    else
    begin
      sync1_q <= {chip_rst_n_i, enc_a_i, enc_b_i, enc_index_n_i,
                  host_cs_n_i, host_rd_n_i, host_wr_n_i, port_select_i, host_data_bus_i};
      sync2_q <= sync1_q;
    end
  end

  logic       prst, a_s, b_s, idx_n_s, cs_n_s, rd_n_s, wr_n_s, ps_s;
  logic [7:0] data_s;
  assign prst    = ~sync2_q[15];
  assign a_s     = sync2_q[14];
  assign b_s     = sync2_q[13];
  assign idx_n_s = sync2_q[12];
  assign cs_n_s  = sync2_q[11];
  assign rd_n_s  = sync2_q[10];
  assign wr_n_s  = sync2_q[9];
  assign ps_s    = sync2_q[8];
  assign data_s  = sync2_q[7:0];

  // ---------------- core state: position, host port, flags
  logic [31:0] pos_q, pos_d, idx_pos_q, idx_pos_d, desired_q, desired_d, err_q, err_d;
  logic [31:0] acc_q, acc_d, rd_sh_q, rd_sh_d, acc_nx, err_abs;
  logic [1:0]  ab_q, ab_d;
  logic [5:0]  flags_q, flags_d, mask_q, mask_d, flag_set, flag_clr;
  logic [15:0] ethr_q, ethr_d, kp_q, kp_d;
  logic [7:0]  ds_q, ds_d, cmd_q, cmd_d, dout_q, dout_d, status_w;
  logic [19:0] ds_cnt_q, ds_cnt_d, ds_lim;
  logic [IW-1:0] init_cnt_q, init_cnt_d;
  logic [2:0]  need_q, need_d;
  logic        armed_q, armed_d, busy_q, busy_d, motor_off_q, motor_off_d, init_done_q, init_done_d;
  logic        at_tgt_q, at_tgt_d, wr_prev_q, rd_prev_q, irq_q, irq_d, tick_q, tick_d;
  logic        wr_rise, rd_rise;

  assign wr_rise  = wr_n_s & ~wr_prev_q & ~cs_n_s;
  assign rd_rise  = rd_n_s & ~rd_prev_q & ~cs_n_s & ps_s;
  assign status_w = init_done_q ? {motor_off_q, flags_q, busy_q} : 8'h00;
  assign acc_nx   = {acc_q[23:0], data_s};
  assign err_abs  = err_q[31] ? -err_q : err_q;
  assign ds_lim   = 20'((({12'h000, ds_q} + 20'h1) * 20'(DS_BASE_P)) - 20'h1);

  always_comb
  begin
    pos_d = pos_q; idx_pos_d = idx_pos_q; desired_d = desired_q; acc_d = acc_q;
    rd_sh_d = rd_sh_q; ab_d = {a_s, b_s}; mask_d = mask_q; ethr_d = ethr_q; kp_d = kp_q;
    ds_d = ds_q; cmd_d = cmd_q; need_d = need_q; armed_d = armed_q; busy_d = 1'b0;
    motor_off_d = motor_off_q; init_done_d = init_done_q; init_cnt_d = init_cnt_q;
    flag_set = 6'h00; flag_clr = 6'h00;
    err_d = desired_q - pos_q;
    at_tgt_d = (pos_q == desired_q);
    ds_cnt_d = (ds_cnt_q >= ds_lim) ? 20'h0 : ds_cnt_q + 20'h1;
    tick_d = (ds_cnt_q >= ds_lim);
    // only single-bit changes are legal steps
    if ((a_s != ab_q[1]) != (b_s != ab_q[0]))
    begin
      if (ab_q[0] ^ a_s)
      begin
        if (pos_q == POS_MAX) flag_set[FL_WRAP] = 1'b1;
        pos_d = pos_q + 32'h1;
      end
      else
      begin
        if (pos_q == POS_MIN) flag_set[FL_WRAP] = 1'b1;
        pos_d = pos_q - 32'h1;
      end
    end
    if (armed_q && !a_s && !b_s && !idx_n_s)
    begin
      // store and alert; includes the step into the all-low state
      idx_pos_d = pos_d;
      armed_d = 1'b0;
      flag_set[FL_INDEX] = 1'b1;
    end
    if (at_tgt_d && !at_tgt_q) flag_set[FL_TRAJ] = 1'b1;
    if (err_abs > {16'h0000, ethr_q}) flag_set[FL_POS_ERR] = 1'b1;
    if (breakpoint_hit_i) flag_set[FL_BREAK] = 1'b1;
    if (!init_done_q)
    begin
      init_cnt_d = init_cnt_q + IW'(1);
      if (init_cnt_q == IW'(INIT_CYCLES_P - 1))
      begin
        init_done_d = 1'b1;
        flag_set[FL_TRAJ] = 1'b1;
      end
    end
    if (rd_rise) rd_sh_d = {rd_sh_q[23:0], 8'h00};
    if (wr_rise)
    begin
      // busy set on the taking edge
      busy_d = 1'b1;
      // port select picks command or data
      if (!ps_s)
      begin
        cmd_d = data_s;
        need_d = 3'h0;
        case (data_s)
          CMD_IRQ_CLR:  flag_clr = 6'h3F;
          CMD_MASK:  need_d = 3'h1;
          CMD_THR_LOAD: need_d = 3'h2;
          CMD_LDES:  need_d = 3'h4;
          CMD_LCOEF: need_d = 3'h2;
          CMD_LDS:   need_d = 3'h1;
          CMD_ARM:   armed_d = 1'b1;
          CMD_RDPOS: rd_sh_d = pos_q;
          CMD_RDIDX: rd_sh_d = idx_pos_q;
          CMD_MTON:  motor_off_d = 1'b0;
          CMD_MTOFF: motor_off_d = 1'b1;
          default:   flag_set[FL_CMD_ERR] = 1'b1;
        endcase
      end
      else if (need_q == 3'h0)
        flag_set[FL_CMD_ERR] = 1'b1;
      else
      begin
        acc_d = acc_nx;
        need_d = need_q - 3'h1;
        if (need_q == 3'h1)
        begin
          case (cmd_q)
            CMD_MASK:  mask_d = acc_nx[5:0];
            CMD_THR_LOAD: ethr_d = acc_nx[15:0];
            CMD_LDES:  desired_d = acc_nx;
            CMD_LCOEF: kp_d = acc_nx[15:0];
            CMD_LDS:   ds_d = acc_nx[7:0];
            default:   ;
          endcase
        end
      end
    end
    // set wins over clear
    flags_d = (flags_q & ~flag_clr) | flag_set;
    // pin reset holds defaults, init starts on release
    if (prst)
    begin
      pos_d = 32'h0; desired_d = 32'h0; kp_d = 16'h0000; idx_pos_d = 32'h0;
      ethr_d = ETHR_RST;
      mask_d = MASK_RST;
      ds_d = 8'h00;
      flags_d = 6'h00; armed_d = 1'b0; need_d = 3'h0; motor_off_d = 1'b1;
      init_done_d = 1'b0; init_cnt_d = '0; ds_cnt_d = 20'h0; tick_d = 1'b0;
    end
    irq_d = init_done_d && |(flags_d & mask_d);
    // read byte latched for the bus
    dout_d = ps_s ? rd_sh_q[31:24] : status_w;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pos_q <= 32'h0; idx_pos_q <= 32'h0; desired_q <= 32'h0; err_q <= 32'h0;
      acc_q <= 32'h0; rd_sh_q <= 32'h0; ab_q <= 2'h0; flags_q <= 6'h00; mask_q <= MASK_RST;
      ethr_q <= ETHR_RST; kp_q <= 16'h0000; ds_q <= 8'h00; cmd_q <= 8'h00; dout_q <= 8'h00;
      ds_cnt_q <= 20'h0; init_cnt_q <= '0; need_q <= 3'h0; armed_q <= 1'b0; busy_q <= 1'b0;
      motor_off_q <= 1'b1; init_done_q <= 1'b0; at_tgt_q <= 1'b1; wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1; irq_q <= 1'b0; tick_q <= 1'b0;
    end
    else
    begin
      pos_q <= pos_d; idx_pos_q <= idx_pos_d; desired_q <= desired_d; err_q <= err_d;
      acc_q <= acc_d; rd_sh_q <= rd_sh_d; ab_q <= ab_d; flags_q <= flags_d; mask_q <= mask_d;
      ethr_q <= ethr_d; kp_q <= kp_d; ds_q <= ds_d; cmd_q <= cmd_d; dout_q <= dout_d;
      ds_cnt_q <= ds_cnt_d; init_cnt_q <= init_cnt_d; need_q <= need_d; armed_q <= armed_d;
      busy_q <= busy_d; motor_off_q <= motor_off_d; init_done_q <= init_done_d;
      at_tgt_q <= at_tgt_d; wr_prev_q <= wr_n_s; rd_prev_q <= rd_n_s; irq_q <= irq_d;
      tick_q <= tick_d;
    end
  end

  assign host_data_bus_o      = dout_q;
  assign host_data_bus_oe_n_o = cs_n_s | rd_n_s;
  assign host_irq_o           = irq_q;
  assign pos_error_o          = err_q;
  assign desired_pos_o        = desired_q;
  assign error_threshold_o    = ethr_q;
  assign filter_coef_o        = kp_q;
  assign deriv_tick_o         = tick_q;
  assign motor_off_o          = motor_off_q;

  // ---------------- motor output port
  logic [11:0] drive_q, drive_d;
  logic [7:0]  port_q, port_d, pwm_q, pwm_d, rev8, mag;
  logic [5:0]  rev6;
  logic [3:0]  rstlen_q, rstlen_d;
  mux_state_t  mux_q, mux_d;
  motor_mode_t eff_mode;

  for (genvar i = 0; i < 8; i++)
  begin : g_rev8
    assign rev8[i] = drive_q[11 - i];
  end
  for (genvar i = 0; i < 6; i++)
  begin : g_rev6
    assign rev6[i] = (mux_q == MX_LO || mux_q == MX_LO_STB) ? drive_q[5 - i] : drive_q[11 - i];
  end

  assign eff_mode = prst ? ((rstlen_q < 4'(RST_MIN_CLOCKS)) ? MODE_12 : MODE_8)
                         : motor_mode_t'(motor_mode_i);
  assign mag = drive_q[11] ? drive_q[10:3] : ~drive_q[10:3];

  always_comb
  begin
    drive_d  = drive_q;
    if (prst || motor_off_q) drive_d = MIDSCALE12;
    else if (filter_valid_i) drive_d = filter_out_i;
    rstlen_d = prst ? ((rstlen_q < 4'(RST_MIN_CLOCKS)) ? rstlen_q + 4'h1 : rstlen_q) : 4'h0;
    pwm_d    = pwm_q + 8'h01;
    unique case (mux_q)
      MX_LO:     mux_d = MX_LO_STB;
      MX_LO_STB: mux_d = MX_HI;
      MX_HI:     mux_d = MX_HI_STB;
      MX_HI_STB: mux_d = MX_LO;
    endcase
    unique case (eff_mode)
      MODE_8:   port_d = rev8;
      // line 6 marks the high word; line 7 rises per word
      MODE_12:  port_d = {(mux_q == MX_LO_STB || mux_q == MX_HI_STB),
                          (mux_q == MX_HI || mux_q == MX_HI_STB), rev6};
      // sign on line 0, magnitude on line 1
      MODE_PWM: port_d = {6'h00, (pwm_q < mag), ~drive_q[11]};
      default:  port_d = rev8;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      drive_q <= MIDSCALE12; port_q <= 8'h01; pwm_q <= 8'h00; rstlen_q <= 4'h0; mux_q <= MX_LO;
    end
    else
    begin
      drive_q <= drive_d; port_q <= port_d; pwm_q <= pwm_d; rstlen_q <= rstlen_d; mux_q <= mux_d;
    end
  end

  assign motor_out_port_o = port_q;

  // ---------------- assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_quiet_status;
    (status_w == 8'h00) [*8];
  endsequence
  sequence s_lo_then_strobe;
    (motor_out_port_o[7:6] == 2'b00) ##1 (motor_out_port_o[7:6] == 2'b10);
  endsequence

  a_index_capture: assert property (armed_q && !a_s && !b_s && !idx_n_s && !prst
    |=> idx_pos_q == pos_q && flags_q[FL_INDEX] && !armed_q) else $error("index capture wrong");
  a_quad_forward: assert property (!prst && ab_q == 2'b00 && a_s && !b_s
    |=> pos_q == $past(pos_q) + 32'h1) else $error("forward step wrong");
  a_quad_reverse: assert property (!prst && ab_q == 2'b00 && !a_s && b_s
    |=> pos_q == $past(pos_q) - 32'h1) else $error("reverse step wrong");
  a_irq_follows: assert property ($rose(flags_q[FL_INDEX]) && mask_q[FL_INDEX] && init_done_q
    |-> host_irq_o) else $error("interrupt missing");
  a_byte_order: assert property (!prst && motor_mode_i == MODE_8
    |=> motor_out_port_o[0] == $past(drive_q[11]) && motor_out_port_o[7] == $past(drive_q[4]))
    else $error("8-bit order wrong");
  a_mux_words: assert property ((eff_mode == MODE_12 && mux_q == MX_LO) ##1 (eff_mode == MODE_12)
    |-> s_lo_then_strobe) else $error("12-bit sequence wrong");
  a_pwm_unused: assert property (!prst && motor_mode_i == MODE_PWM
    |=> motor_out_port_o[7:2] == 6'h00) else $error("pwm lines driven");
  a_reset_values: assert property (prst
    |=> ethr_q == ETHR_RST && mask_q == MASK_RST && ds_q == 8'h00 && pos_q == 32'h0 && kp_q == 16'h0000)
    else $error("reset defaults wrong");
  a_reset_midscale: assert property (prst && rstlen_q >= 4'(RST_MIN_CLOCKS)
    |=> motor_out_port_o == 8'h01 || !prst) else $error("8-bit mid-scale missing");
  a_status_init: assert property ($fell(prst) |-> s_quiet_status) else $error("status not 00");
  a_status_ready: assert property ($rose(init_done_q)
    |-> status_w[7:1] == STATUS_INIT[7:1]) else $error("status not 84");
  a_busy_set: assert property (wr_rise && !prst |=> busy_q && status_w[0] == init_done_q)
    else $error("busy late");
  a_error_path: assert property (##1 pos_error_o == $past(desired_q) - $past(pos_q))
    else $error("position error wrong");

endmodule // servo_pins
`default_nettype wire

// ### verif/host_port_model.sv
/*
  Host processor model: byte writes and reads on the 8-bit servo host port.
  Assumes the device samples strobes, select and data through 2-flop synchronisers.
*/
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  input  wire logic       clk_i,       // system clock
  input  wire logic [7:0] dev_d_i,     // device bus drive value
  input  wire logic       dev_oe_n_i,  // device enable, low drives
  output logic            cs_n_o,      // device select
  output logic            rd_n_o,      // read strobe
  output logic            wr_n_o,      // write strobe
  output logic            ps_o,        // port select
  output logic      [7:0] bus_o        // resolved bus level
);
  logic [7:0] drv_q;
  logic       hdrv_q;
  logic [7:0] last_q;
  initial
  begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ps_o   = 1'b0;
    drv_q  = 8'h00;
    hdrv_q = 1'b0;
    last_q = 8'h00;
  end
  // floating bus shows a changing pattern, never a stale byte
  assign bus_o = !dev_oe_n_i ? dev_d_i : (hdrv_q ? drv_q : ~last_q);
  always @(posedge clk_i) last_q <= bus_o;
  // byte write, select and data held past strobe release
  task automatic wr(input logic ps, input logic [7:0] b);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    ps_o   <= ps;
    drv_q  <= b;
    hdrv_q <= 1'b1;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    hdrv_q <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // byte read; select held so the data pointer advances
  task automatic rd(input logic ps, output logic [7:0] b);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    ps_o   <= ps;
    rd_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    b = bus_o;
    @(posedge clk_i);
    rd_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // host_port_model
`default_nettype wire

// ### verif/servo_pins_test.sv
/*
  Self-checking bench for servo_pins: reset defaults, status, commands, encoder, index, motor port.
  Assumes shortened init and derivative counts, and the host model as bus partner.
*/
`timescale 1ns/10ps
`default_nettype none
module servo_pins_test;
  import servo_pins_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, chip_rst_n_i = 1'b1, enc_a_i = 1'b0, enc_b_i = 1'b0;
  logic enc_index_n_i = 1'b1, fval = 1'b0, bph = 1'b0;
  logic [1:0] mode = MODE_8;
  logic [11:0] fout = 12'h800;
  logic cs_n, rd_n, wr_n, ps, oe_n, irq, tick, moff;
  logic [7:0] bus, d_o, port, s;
  logic [15:0] ethr, coef;
  logic [31:0] perr, dpos, v;
  int num_errors = 0;
  int n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  host_port_model host_u (.clk_i(clk_i), .dev_d_i(d_o), .dev_oe_n_i(oe_n), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .ps_o(ps), .bus_o(bus));
  servo_pins #(.INIT_CYCLES_P(20), .DS_BASE_P(8)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .chip_rst_n_i(chip_rst_n_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .enc_index_n_i(enc_index_n_i),
    .host_cs_n_i(cs_n), .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .port_select_i(ps), .host_data_bus_i(bus),
    .host_data_bus_o(d_o), .host_data_bus_oe_n_o(oe_n), .host_irq_o(irq), .motor_mode_i(mode),
    .filter_out_i(fout), .filter_valid_i(fval), .breakpoint_hit_i(bph), .motor_out_port_o(port),
    .pos_error_o(perr), .desired_pos_o(dpos), .error_threshold_o(ethr), .filter_coef_o(coef),
    .deriv_tick_o(tick), .motor_off_o(moff));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // sel 1 pulses filter valid, 0 pulses breakpoint
  task automatic pulse(input logic sel);
    @(posedge clk_i);
    if (sel)
      fval <= 1'b1;
    else
      bph <= 1'b1;
    @(posedge clk_i);
    fval <= 1'b0;
    bph <= 1'b0;
  endtask
  // each state dwells past 8 clocks
  task automatic enc(input logic a, input logic b);
    @(posedge clk_i);
    enc_a_i <= a;
    enc_b_i <= b;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic rd32(input logic [7:0] c);
    host_u.wr(1'b0, c);
    v = 32'h0;
    repeat (4)
    begin
      host_u.rd(1'b1, s);
      v = {v[23:0], s};
    end
  endtask
  function automatic logic [5:0] rev6(input logic [5:0] x);
    return {x[0], x[1], x[2], x[3], x[4], x[5]};
  endfunction
  task automatic t_reset;
    logic seen12;
    int n;
    seen12 = 1'b0;
    @(posedge clk_i);
    // low for well over 8 clocks plus sync
    chip_rst_n_i <= 1'b0;
    repeat (14)
    begin
      @(negedge clk_i);
      if (port[6] === 1'b1 && port[5:0] === 6'h01)
        seen12 = 1'b1;
    end
    repeat (6) @(negedge clk_i);
    chk("mid-scale 12-bit high word", seen12, 1'b1);
    chk("mid-scale 8-bit reversed", port, 8'h01);
    chk("threshold", ethr, 16'h7FFF);
    chk("coefficient", coef, 16'h0);
    chk("desired", dpos, 32'h0);
    chk("position error", perr, 32'h0);
    @(posedge clk_i);
    chip_rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    host_u.rd(1'b0, s);
    chk("status after release", s, 8'h00);
    repeat (30) @(posedge clk_i);
    host_u.rd(1'b0, s);
    chk("status after init", s, 8'h84);
    chk("irq on done", irq, 1'b1);
    do
    begin
      @(negedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 40);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 40);
    chk("derivative period", n, 8);
    $display("test reset done");
  endtask
  task automatic t_cmds;
    host_u.wr(1'b0, 8'hFF);
    host_u.rd(1'b0, s);
    chk("unknown command", s, 8'h86);
    host_u.wr(1'b0, CMD_IRQ_CLR);
    host_u.rd(1'b0, s);
    chk("status after clear", s, 8'h80);
    chk("irq after clear", irq, 1'b0);
    pulse(1'b0);
    host_u.rd(1'b0, s);
    chk("breakpoint flag", s, 8'hC0);
    chk("breakpoint masked", irq, 1'b0);
    host_u.wr(1'b0, CMD_MASK);
    host_u.wr(1'b1, 8'h3F);
    chk("breakpoint enabled irq", irq, 1'b1);
    host_u.wr(1'b0, CMD_IRQ_CLR);
    chk("irq cleared", irq, 1'b0);
    $display("test commands done");
  endtask
  task automatic t_enc;
    repeat (2)
    begin
      enc(1'b1, 1'b0);
      enc(1'b1, 1'b1);
      enc(1'b0, 1'b1);
      enc(1'b0, 1'b0);
    end
    rd32(CMD_RDPOS);
    chk("forward count", v, 32'd8);
    chk("error desired minus actual", perr, 32'hFFFFFFF8);
    host_u.wr(1'b0, CMD_ARM);
    enc(1'b1, 1'b0);
    @(posedge clk_i);
    enc_index_n_i <= 1'b0;
    host_u.rd(1'b0, s);
    chk("no capture with A high", s[3], 1'b0);
    enc(1'b0, 1'b0);
    host_u.rd(1'b0, s);
    chk("index flag", s[3], 1'b1);
    chk("index irq", irq, 1'b1);
    @(posedge clk_i);
    enc_index_n_i <= 1'b1;
    rd32(CMD_RDIDX);
    chk("index position", v, 32'd8);
    enc(1'b0, 1'b1);
    rd32(CMD_RDPOS);
    chk("reverse count", v, 32'd7);
    enc(1'b0, 1'b0);
    host_u.wr(1'b0, CMD_IRQ_CLR);
    $display("test encoder done");
  endtask
  task automatic t_motor;
    logic pv;
    int nr;
    logic orr;
    logic hi1;
    logic lo1;
    nr = 0;
    host_u.wr(1'b0, CMD_MTON);
    chk("motor on", moff, 1'b0);
    @(posedge clk_i);
    mode <= MODE_12;
    fout <= 12'hA5C;
    pulse(1'b1);
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    pv = port[7];
    repeat (16)
    begin
      @(negedge clk_i);
      if (port[7] === 1'b1 && pv === 1'b0)
        nr++;
      pv = port[7];
      chk("12-bit word", port[5:0], port[6] ? rev6(6'h29) : rev6(6'h1C));
    end
    chk("strobe rises", nr, 8);
    @(posedge clk_i);
    mode <= MODE_PWM;
    fout <= 12'h700;
    pulse(1'b1);
    repeat (4) @(posedge clk_i);
    orr = 1'b0;
    hi1 = 1'b0;
    lo1 = 1'b0;
    repeat (300)
    begin
      @(negedge clk_i);
      orr = orr | (|port[7:2]) | ~port[0];
      hi1 = hi1 | (port[1] === 1'b1);
      lo1 = lo1 | (port[1] === 1'b0);
    end
    chk("pwm sign and idle lines", orr, 1'b0);
    chk("pwm magnitude toggles", {hi1, lo1}, 2'b11);
    host_u.wr(1'b0, CMD_MTOFF);
    $display("test motor done");
  endtask
  initial
  begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_cmds();
    t_enc();
    t_motor();
    test_done();
  end
endmodule // servo_pins_test
`default_nettype wire
